/* verilog/pfccfg_consts.vh */
// Constants for the configuration register bank and fault response block.
// Assumes inclusion by bare name from the design files under verilog/.
`ifndef PFCCFG_CONSTS_VH
`define PFCCFG_CONSTS_VH

// Byte offsets of the register map (low byte first in each pair).
`define PFCCFG_HL_TARGET_LO   8'h01
`define PFCCFG_HL_TARGET_HI   8'h02
`define PFCCFG_LL_TARGET_LO   8'h03
`define PFCCFG_LL_TARGET_HI   8'h04
`define PFCCFG_LINE_THRESH    8'h05
`define PFCCFG_LOAD_ONE_LO    8'h06
`define PFCCFG_LOAD_ONE_HI    8'h07
`define PFCCFG_LOAD_TWO_LO    8'h08
`define PFCCFG_LOAD_TWO_HI    8'h09
`define PFCCFG_BURST_EXIT     8'h0A
`define PFCCFG_LOAD_HYST_LO   8'h0C
`define PFCCFG_LOAD_HYST_HI   8'h0D
`define PFCCFG_HL_LVL1_LO     8'h0E
`define PFCCFG_HL_LVL2_LO     8'h0F

// Writable masks for the upper byte of each pair and for the burst byte.
`define PFCCFG_MASK_10_HI     8'h03
`define PFCCFG_MASK_14_HI     8'h3F
`define PFCCFG_MASK_5         8'h1F

// Reset values.
`define PFCCFG_RST_TARGET     10'h31E
`define PFCCFG_RST_LINE       8'h71
`define PFCCFG_RST_LOAD_ONE   14'h03FC
`define PFCCFG_RST_LOAD_TWO   14'h0064
`define PFCCFG_RST_BURST      5'h17
`define PFCCFG_RST_HYST       14'h00F5
`define PFCCFG_RST_LVL_LO     8'h1E

// Restart timer length in milliseconds and cycles at 25 MHz.
`define PFCCFG_TIMER_MS       10
`define PFCCFG_CLK_KHZ        25000
`define PFCCFG_TIMER_CYC      (`PFCCFG_TIMER_MS * `PFCCFG_CLK_KHZ)

`endif

/* verilog/pfccfg_sync.v */
// Three-stage synchroniser with agreement filter for asynchronous inputs.
// Assumes a single clock clk_i and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module pfccfg_sync #(
  parameter W = 1                  // Number of bits synchronised.
) (
  input  wire         clk_i,       // System clock.
  input  wire         rst_i,       // Synchronous reset, active high.
  input  wire [W-1:0] async_i,     // Asynchronous inputs.
  output reg  [W-1:0] sync_o       // Filtered, synchronised inputs.
);

  reg [W-1:0] s1_reg;              // First stage, read only by second.
  reg [W-1:0] s2_reg;              // Second stage.
  reg [W-1:0] s3_reg;              // Third stage.
  integer     i;                   // Bit loop index.

  // Shift inputs through three stages; output follows once two agree.
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sync_o[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule // pfccfg_sync

`default_nettype wire

/* verilog/pfccfg_regs.v */
// Byte-wide configuration storage with masked writes and registered reads.
// Assumes a simple write strobe and read strobe from the top block.
`timescale 1ns/10ps
`default_nettype none
`include "pfccfg_consts.vh"

module pfccfg_regs (
  input  wire        clk_i,        // System clock.
  input  wire        rst_i,        // Synchronous reset, active high.
  input  wire [7:0]  addr_i,       // Register byte offset.
  input  wire        wr_i,         // Write strobe, one cycle.
  input  wire [7:0]  wdata_i,      // Write data.
  input  wire        rd_i,         // Read strobe, one cycle.
  output reg  [7:0]  rdata_o,      // Registered read data.
  output reg  [9:0]  hl_target_o,  // High-line output target.
  output reg  [9:0]  ll_target_o,  // Low-line output target.
  output reg  [7:0]  line_thr_o,   // Line level threshold.
  output reg  [13:0] load_one_o,   // Auto target load level one.
  output reg  [13:0] load_two_o,   // Auto target load level two.
  output reg  [4:0]  burst_o,      // Burst exit threshold.
  output reg  [13:0] hyst_o,       // Auto target load hysteresis.
  output reg  [7:0]  lvl1_lo_o,    // High-line level one low byte.
  output reg  [7:0]  lvl2_lo_o     // High-line level two low byte.
);

  // Registered writes; read-only upper bits are never stored. [R22]
  always @(posedge clk_i) begin
    if (rst_i) begin
      hl_target_o <= `PFCCFG_RST_TARGET;   // [R01]
      ll_target_o <= `PFCCFG_RST_TARGET;   // [R02]
      line_thr_o  <= `PFCCFG_RST_LINE;     // [R03]
      load_one_o  <= `PFCCFG_RST_LOAD_ONE; // [R04]
      load_two_o  <= `PFCCFG_RST_LOAD_TWO; // [R05]
      burst_o     <= `PFCCFG_RST_BURST;    // [R06]
      hyst_o      <= `PFCCFG_RST_HYST;     // [R07]
      lvl1_lo_o   <= `PFCCFG_RST_LVL_LO;   // [R08]
      lvl2_lo_o   <= `PFCCFG_RST_LVL_LO;   // [R09]
    end else if (wr_i) begin
      case (addr_i)
        `PFCCFG_HL_TARGET_LO: hl_target_o[7:0] <= wdata_i;    // [R01]
        `PFCCFG_HL_TARGET_HI: hl_target_o[9:8] <= wdata_i[1:0]; // [R01]
        `PFCCFG_LL_TARGET_LO: ll_target_o[7:0] <= wdata_i;    // [R02]
        `PFCCFG_LL_TARGET_HI: ll_target_o[9:8] <= wdata_i[1:0]; // [R02]
        `PFCCFG_LINE_THRESH:  line_thr_o <= wdata_i;          // [R03]
        `PFCCFG_LOAD_ONE_LO:  load_one_o[7:0] <= wdata_i;     // [R04]
        `PFCCFG_LOAD_ONE_HI:  load_one_o[13:8] <= wdata_i[5:0]; // [R04]
        `PFCCFG_LOAD_TWO_LO:  load_two_o[7:0] <= wdata_i;     // [R05]
        `PFCCFG_LOAD_TWO_HI:  load_two_o[13:8] <= wdata_i[5:0]; // [R05]
        `PFCCFG_BURST_EXIT:   burst_o <= wdata_i[4:0];        // [R06]
        `PFCCFG_LOAD_HYST_LO: hyst_o[7:0] <= wdata_i;         // [R07]
        `PFCCFG_LOAD_HYST_HI: hyst_o[13:8] <= wdata_i[5:0];   // [R07]
        `PFCCFG_HL_LVL1_LO:   lvl1_lo_o <= wdata_i;           // [R08]
        `PFCCFG_HL_LVL2_LO:   lvl2_lo_o <= wdata_i;           // [R09]
        default: begin
          // Unmapped offsets ignore writes.
        end
      endcase
    end
  end

  // Registered read mux; read-only bits and unmapped offsets give zero.
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `PFCCFG_HL_TARGET_LO: rdata_o <= hl_target_o[7:0];
        `PFCCFG_HL_TARGET_HI: rdata_o <= {6'h00, hl_target_o[9:8]}; // [R22]
        `PFCCFG_LL_TARGET_LO: rdata_o <= ll_target_o[7:0];
        `PFCCFG_LL_TARGET_HI: rdata_o <= {6'h00, ll_target_o[9:8]}; // [R22]
        `PFCCFG_LINE_THRESH:  rdata_o <= line_thr_o;
        `PFCCFG_LOAD_ONE_LO:  rdata_o <= load_one_o[7:0];
        `PFCCFG_LOAD_ONE_HI:  rdata_o <= {2'h0, load_one_o[13:8]}; // [R22]
        `PFCCFG_LOAD_TWO_LO:  rdata_o <= load_two_o[7:0];
        `PFCCFG_LOAD_TWO_HI:  rdata_o <= {2'h0, load_two_o[13:8]}; // [R22]
        `PFCCFG_BURST_EXIT:   rdata_o <= {3'h0, burst_o};          // [R22]
        `PFCCFG_LOAD_HYST_LO: rdata_o <= hyst_o[7:0];
        `PFCCFG_LOAD_HYST_HI: rdata_o <= {2'h0, hyst_o[13:8]};     // [R22]
        `PFCCFG_HL_LVL1_LO:   rdata_o <= lvl1_lo_o;
        `PFCCFG_HL_LVL2_LO:   rdata_o <= lvl2_lo_o;
        default:              rdata_o <= 8'h00;
      endcase
    end
  end

endmodule // pfccfg_regs

`default_nettype wire

/* verilog/pfccfg_top.v */
// Configuration register bank and fault response logic of the controller.
// Assumes a byte register port driven by an I2C command decoder, and fault
// comparator outputs arriving asynchronously as active-high levels.
//
// Contract
// R01 - 10-bit high-line target, default 0x31E.
// R02 - 10-bit low-line target, same split, default.
// R03 - 8-bit line threshold, default 0x71.
// R04 - 14-bit load level one, default 0x3FC.
// R05 - 14-bit load level two, default 0x064.
// R06 - 5-bit burst exit threshold, default 0x17.
// R07 - 14-bit load hysteresis, default 0x0F5.
// R08 - High-line level one low byte, 0x1E.
// R09 - High-line level two low byte, 0x1E.
// R10 - Supply UV disables; short also limits source.
// R11 - Shutdown threshold shuts system, latched off.
// R12 - Latch clears only at supply reset threshold.
// R13 - Startup failure stops system until timer.
// R14 - Overtemp disables; brown-out suspends system switching.
// R15 - PF current limit: restart or latch, PF.
// R16 - PF overvoltage suspends power-factor stage only.
// R17 - PF open loop stops system, auto recovers.
// R18 - PF or resonant undervoltage suspends half-bridge.
// R19 - HB current regulation stops HB until timer.
// R20 - HB current protection shuts HB until timer.
// R21 - Capacitive mode raises half-bridge switching frequency.
// R22 - Read-only upper bits read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "pfccfg_consts.vh"

module pfccfg_top #(
  parameter TIMER_CYC = `PFCCFG_TIMER_CYC  // Restart timer length.
) (
  input  wire        clk_i,            // System clock, 25 MHz.
  input  wire        rst_i,            // Synchronous reset, active high.
  input  wire [7:0]  reg_addr_i,       // Register byte offset.
  input  wire        reg_wr_i,         // Register write strobe.
  input  wire [7:0]  reg_wdata_i,      // Register write data.
  input  wire        reg_rd_i,         // Register read strobe.
  output wire [7:0]  reg_rdata_o,      // Read data, valid cycle after rd.
  input  wire        pf_latch_mode_i,  // PF current limit: 1 latch, 0 restart.
  input  wire        supply_undervoltage_i,       // Supply UV level.
  input  wire        supply_short_circuit_i,      // Supply short level.
  input  wire        supply_reset_threshold_i,    // Supply below reset.
  input  wire        shutdown_latch_threshold_i,  // Shutdown sense trip.
  input  wire        startup_failure_threshold_i, // Startup failure trip.
  input  wire        over_temperature_i,          // Over-temperature.
  input  wire        brown_out_i,                 // Line brown-out.
  input  wire        power_factor_current_limit_i,      // PF current limit.
  input  wire        power_factor_overvoltage_i,        // PF overvoltage.
  input  wire        power_factor_open_loop_i,          // PF open loop.
  input  wire        power_factor_output_undervoltage_i, // PF output UV.
  input  wire        resonant_undervoltage_i,           // Resonant stage UV.
  input  wire        half_bridge_current_regulation_i,  // HB current reg.
  input  wire        half_bridge_current_protection_i,  // HB current prot.
  input  wire        capacitive_mode_regulation_i,      // Capacitive mode.
  output reg         system_enable_o,       // Whole system allowed to run.
  output reg         limit_source_o,        // Limit startup source current.
  output reg         pf_enable_o,           // Power-factor stage switching.
  output reg         hb_enable_o,           // Half-bridge stage switching.
  output reg         hb_freq_raise_o,       // Raise half-bridge frequency.
  output reg         shutdown_latched_o,    // Latched-off state.
  output reg         pf_latched_o,          // PF current-limit latch-off.
  output reg         sys_timer_active_o,    // System restart timer running.
  output reg         hb_timer_active_o,     // HB restart timer running.
  output wire [9:0]  hl_target_o,           // High-line output target.
  output wire [9:0]  ll_target_o,           // Low-line output target.
  output wire [7:0]  line_thr_o,            // Line level threshold.
  output wire [13:0] load_one_o,            // Load level one.
  output wire [13:0] load_two_o,            // Load level two.
  output wire [4:0]  burst_o,               // Burst exit threshold.
  output wire [13:0] hyst_o,                // Load hysteresis.
  output wire [7:0]  lvl1_lo_o,             // Level one low byte.
  output wire [7:0]  lvl2_lo_o              // Level two low byte.
);

  localparam NF = 15;                 // Number of fault inputs.
  localparam [31:0] TMAX = TIMER_CYC; // Timer length at counter width.

  wire [NF-1:0] f_raw;                // Raw fault levels.
  wire [NF-1:0] f;                    // Synchronised fault levels.
  reg  [31:0]   sys_cnt_reg;          // System restart timer count.
  reg  [31:0]   hb_cnt_reg;           // Half-bridge restart timer count.
  reg  [31:0]   pf_cnt_reg;           // PF restart timer count.
  reg           pf_timer_reg;         // PF restart timer running.

  // Gather fault levels into one vector for synchronising.
  assign f_raw = {capacitive_mode_regulation_i,
                  half_bridge_current_protection_i,
                  half_bridge_current_regulation_i,
                  resonant_undervoltage_i,
                  power_factor_output_undervoltage_i,
                  power_factor_open_loop_i,
                  power_factor_overvoltage_i,
                  power_factor_current_limit_i,
                  brown_out_i,
                  over_temperature_i,
                  startup_failure_threshold_i,
                  shutdown_latch_threshold_i,
                  supply_reset_threshold_i,
                  supply_short_circuit_i,
                  supply_undervoltage_i};

  // Named views of the synchronised faults.
  wire s_uv   = f[0];                 // Supply undervoltage.
  wire s_sc   = f[1];                 // Supply short circuit.
  wire s_rst  = f[2];                 // Supply below reset threshold.
  wire s_lat  = f[3];                 // Shutdown latch threshold.
  wire s_sfp  = f[4];                 // Startup failure.
  wire s_otp  = f[5];                 // Over-temperature.
  wire s_bo   = f[6];                 // Brown-out.
  wire p_ocp  = f[7];                 // PF current limit.
  wire p_ovp  = f[8];                 // PF overvoltage.
  wire p_olp  = f[9];                 // PF open loop.
  wire p_uvp  = f[10];                // PF output undervoltage.
  wire h_uvp  = f[11];                // Resonant undervoltage.
  wire h_ocr  = f[12];                // HB current regulation.
  wire h_ocp  = f[13];                // HB current protection.
  wire h_cmr  = f[14];                // Capacitive mode.

  // Pin-side faults pass three flops with agreement filter.
  pfccfg_sync #(
    .W       (NF)
  ) i_pfccfg_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (f_raw),
    .sync_o  (f)
  );

  // Configuration storage reached through the byte register port.
  pfccfg_regs i_pfccfg_regs (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .addr_i      (reg_addr_i),
    .wr_i        (reg_wr_i),
    .wdata_i     (reg_wdata_i),
    .rd_i        (reg_rd_i),
    .rdata_o     (reg_rdata_o),
    .hl_target_o (hl_target_o),
    .ll_target_o (ll_target_o),
    .line_thr_o  (line_thr_o),
    .load_one_o  (load_one_o),
    .load_two_o  (load_two_o),
    .burst_o     (burst_o),
    .hyst_o      (hyst_o),
    .lvl1_lo_o   (lvl1_lo_o),
    .lvl2_lo_o   (lvl2_lo_o)
  );

  // Shutdown latch: sets on trip, clears only at supply reset; set wins.
  always @(posedge clk_i) begin
    if (rst_i) begin
      shutdown_latched_o <= 1'b0;
    end else if (s_lat) begin
      shutdown_latched_o <= 1'b1;                      // [R11]
    end else if (s_rst) begin
      shutdown_latched_o <= 1'b0;                      // [R12]
    end
  end

  // System restart timer: startup failure and open loop stop the system
  // for one timer period, then it restarts on its own.
  always @(posedge clk_i) begin
    if (rst_i) begin
      sys_timer_active_o <= 1'b0;
      sys_cnt_reg        <= 32'h00000000;
    end else if (s_sfp || p_olp) begin
      sys_timer_active_o <= 1'b1;                      // [R13] [R17]
      sys_cnt_reg        <= 32'h00000000;
    end else if (sys_timer_active_o) begin
      if (sys_cnt_reg >= TMAX - 32'h00000001) begin
        sys_timer_active_o <= 1'b0;                    // [R13] [R17]
      end else begin
        sys_cnt_reg <= sys_cnt_reg + 32'h00000001;
      end
    end
  end

  // Half-bridge restart timer for current regulation and protection.
  always @(posedge clk_i) begin
    if (rst_i) begin
      hb_timer_active_o <= 1'b0;
      hb_cnt_reg        <= 32'h00000000;
    end else if (h_ocr || h_ocp) begin
      hb_timer_active_o <= 1'b1;                       // [R19] [R20]
      hb_cnt_reg        <= 32'h00000000;
    end else if (hb_timer_active_o) begin
      if (hb_cnt_reg >= TMAX - 32'h00000001) begin
        hb_timer_active_o <= 1'b0;                     // [R19] [R20]
      end else begin
        hb_cnt_reg <= hb_cnt_reg + 32'h00000001;
      end
    end
  end

  // PF current limit: latch-off mode holds until supply reset; restart
  // mode holds the PF stage off for one timer period.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pf_latched_o <= 1'b0;
      pf_timer_reg <= 1'b0;
      pf_cnt_reg   <= 32'h00000000;
    end else begin
      if (p_ocp && pf_latch_mode_i) begin
        pf_latched_o <= 1'b1;                          // [R15]
      end else if (s_rst) begin
        pf_latched_o <= 1'b0;
      end
      if (p_ocp && !pf_latch_mode_i) begin
        pf_timer_reg <= 1'b1;                          // [R15]
        pf_cnt_reg   <= 32'h00000000;
      end else if (pf_timer_reg) begin
        if (pf_cnt_reg >= TMAX - 32'h00000001) begin
          pf_timer_reg <= 1'b0;
        end else begin
          pf_cnt_reg <= pf_cnt_reg + 32'h00000001;
        end
      end
    end
  end

  // Combine fault states into registered stage enables.
  always @(posedge clk_i) begin
    if (rst_i) begin
      system_enable_o <= 1'b0;
      limit_source_o  <= 1'b0;
      pf_enable_o     <= 1'b0;
      hb_enable_o     <= 1'b0;
      hb_freq_raise_o <= 1'b0;
    end else begin
      system_enable_o <= !(s_uv || s_sc || s_otp || s_bo         // [R10] [R14]
                           || s_lat || shutdown_latched_o        // [R11]
                           || s_sfp || sys_timer_active_o        // [R13]
                           || p_olp);                            // [R17]
      limit_source_o  <= s_sc;                                   // [R10]
      pf_enable_o     <= !(p_ovp || p_ocp || pf_latched_o        // [R16]
                           || pf_timer_reg);                     // [R15]
      hb_enable_o     <= !(p_uvp || h_uvp                        // [R18]
                           || h_ocr || h_ocp || hb_timer_active_o); // [R19]
      hb_freq_raise_o <= h_cmr;                                  // [R21]
    end
  end

endmodule // pfccfg_top

`default_nettype wire

/* sim/pfccfg_top_chk.sv */
// Checker for the configuration bank and fault response top block.
// Assumes binding into pfccfg_top, one clock and a synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module pfccfg_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        supply_short_circuit_i,
  input wire logic        supply_reset_threshold_i,
  input wire logic        over_temperature_i,
  input wire logic        power_factor_overvoltage_i,
  input wire logic        half_bridge_current_protection_i,
  input wire logic        capacitive_mode_regulation_i,
  input wire logic        system_enable_o,
  input wire logic        limit_source_o,
  input wire logic        pf_enable_o,
  input wire logic        hb_enable_o,
  input wire logic        hb_freq_raise_o,
  input wire logic        shutdown_latched_o,
  input wire logic        hb_timer_active_o,
  input wire logic [9:0]  hl_target_o,
  input wire logic [9:0]  ll_target_o,
  input wire logic [7:0]  line_thr_o,
  input wire logic [4:0]  burst_o,
  input wire logic [13:0] hyst_o
);
  // All checks share the one clock and are off while reset is high.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  rst_dflt_a: assert property ($fell(rst_i) |->
    hl_target_o == 10'h31E && ll_target_o == 10'h31E &&
    line_thr_o == 8'h71 && burst_o == 5'h17 && hyst_o == 14'h00F5)
    else $error("config outputs not at defaults");
  hl_low_wr_a: assert property (reg_wr_i && reg_addr_i == 8'h01 |=>
    hl_target_o[7:0] == $past(reg_wdata_i)) else $error("target low byte");
  hl_high_wr_a: assert property (reg_wr_i && reg_addr_i == 8'h02
    |=> {6'h00, hl_target_o[9:8]} == ($past(reg_wdata_i) & 8'h03))
    else $error("target high bits");
  burst_wr_a: assert property (reg_wr_i && reg_addr_i == 8'h0A
    |=> {3'h0, burst_o} == ($past(reg_wdata_i) & 8'h1F)) else $error("burst");
  temp_off_a: assert property (over_temperature_i[*8] |->
    !system_enable_o) else $error("system runs in over-temperature");
  short_limit_a: assert property (supply_short_circuit_i[*8] |->
    limit_source_o && !system_enable_o) else $error("supply short");
  pf_ov_off_a: assert property (power_factor_overvoltage_i[*8] |->
    !pf_enable_o) else $error("power-factor stage runs in overvoltage");
  cap_raise_a: assert property (capacitive_mode_regulation_i[*8] |->
    hb_freq_raise_o) else $error("frequency not raised");
  hb_prot_off_a: assert property (half_bridge_current_protection_i[*8]
    |-> !hb_enable_o && hb_timer_active_o) else $error("half-bridge runs");
  latch_hold_a: assert property ((!supply_reset_threshold_i)[*6] ##0
    shutdown_latched_o |=> shutdown_latched_o) else $error("latch let go");

  // Main scenarios that the bench should reach.
  cover property (reg_wr_i && reg_addr_i == 8'h02);
  cover property (shutdown_latched_o);
  cover property (hb_timer_active_o);
endmodule // pfccfg_chk

bind pfccfg_top pfccfg_chk i_pfccfg_chk (.*);
`default_nettype wire

/* sim/pfccfg_host.sv */
// Host model driving the byte register port, as a programming tool would.
// Assumes the bench calls write and read; strobes move at falling edges.
`timescale 1ns/10ps
`default_nettype none
module pfccfg_host (
  input  wire logic       clk_i,    // System clock.
  input  wire logic [7:0] rdata_i,  // Read data from the bank.
  output var  logic [7:0] addr_o,   // Register offset.
  output var  logic [7:0] wdata_o,  // Write data.
  output var  logic       wr_o,     // Write strobe.
  output var  logic       rd_o      // Read strobe.
);
  // Port starts idle.
  initial {addr_o, wdata_o, wr_o, rd_o} = 18'h00000;
  // One write; lines turn to their inverse once taken, so stale data shows.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // One read; the registered answer is taken a cycle after the strobe.
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule // pfccfg_host
`default_nettype wire

/* sim/test_pfccfg_top.sv */
// Self-checking bench for the configuration bank and fault response block.
// Assumes a 25 MHz clock and a shortened restart timer of TCYC cycles.
`timescale 1ns/10ps
`default_nettype none
module test_pfccfg_top;
  localparam int TCYC = 16;     // Restart timer length in simulation.
  logic        clk_i = 1'b0;    // System clock.
  logic        rst_i = 1'b1;    // Synchronous reset.
  logic        lmode = 1'b0;    // Current limit response selection.
  logic [14:0] flt = 15'h0000;  // Fault inputs in port order.
  logic [7:0]  addr, wdata, rdata, lt, l1, l2;
  logic        wr, rd;
  logic        sys, lim, pfe, hbe, frq, sdl, pfl, stm, htm;
  logic [9:0]  hlt, llt;
  logic [13:0] ld1, ld2, hys;
  logic [4:0]  bst, st;
  int          fails = 0;
  int          checks_done = 0;
  logic [7:0]  dflt [17] = '{8'h00, 8'h1E, 8'h03, 8'h1E, 8'h03, 8'h71,
    8'hFC, 8'h03, 8'h64, 8'h00, 8'h17, 8'h00, 8'hF5, 8'h00, 8'h1E, 8'h1E,
    8'h00};
  logic [7:0]  msk [17] = '{8'h00, 8'hFF, 8'h03, 8'hFF, 8'h03, 8'hFF,
    8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'h1F, 8'h00, 8'hFF, 8'h3F, 8'hFF, 8'hFF,
    8'h00};
  assign st = {sys, lim, pfe, hbe, frq};
  always #20 clk_i = ~clk_i;

  pfccfg_host i_pfccfg_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  pfccfg_top #(.TIMER_CYC(TCYC)) i_pfccfg_top (.clk_i(clk_i), .rst_i(rst_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .pf_latch_mode_i(lmode),
    .supply_undervoltage_i(flt[0]), .supply_short_circuit_i(flt[1]),
    .supply_reset_threshold_i(flt[2]), .shutdown_latch_threshold_i(flt[3]),
    .startup_failure_threshold_i(flt[4]), .over_temperature_i(flt[5]),
    .brown_out_i(flt[6]), .power_factor_current_limit_i(flt[7]),
    .power_factor_overvoltage_i(flt[8]), .power_factor_open_loop_i(flt[9]),
    .power_factor_output_undervoltage_i(flt[10]),
    .resonant_undervoltage_i(flt[11]),
    .half_bridge_current_regulation_i(flt[12]),
    .half_bridge_current_protection_i(flt[13]),
    .capacitive_mode_regulation_i(flt[14]), .system_enable_o(sys),
    .limit_source_o(lim), .pf_enable_o(pfe), .hb_enable_o(hbe),
    .hb_freq_raise_o(frq), .shutdown_latched_o(sdl), .pf_latched_o(pfl),
    .sys_timer_active_o(stm), .hb_timer_active_o(htm), .hl_target_o(hlt),
    .ll_target_o(llt), .line_thr_o(lt), .load_one_o(ld1), .load_two_o(ld2),
    .burst_o(bst), .hyst_o(hys), .lvl1_lo_o(l1), .lvl2_lo_o(l2));

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic summarize;
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic do_reset;
    rst_i = 1'b1;
    cyc(4);
    rst_i = 1'b0;
  endtask
  // Enable and timer flag of the system or of the half-bridge stage.
  function automatic logic [15:0] tv(input bit hb);
    return hb ? {14'h0000, hbe, htm} : {14'h0000, sys, stm};
  endfunction

  // Offsets 0x00 to 0x10, unmapped ones among them too, read their reset byte.
  task automatic t_defaults;
    logic [15:0] v, e;
    v = 16'h0000;
    for (int a = 0; a < 17; a++) begin
      i_pfccfg_host.read(a[7:0], v[7:0]);
      e = {8'h00, dflt[a]};
      chk(v, e);
    end
  endtask
  // A pattern written everywhere sticks only in writable bits.
  task automatic t_write;
    logic [15:0] v, e;
    v = 16'h0000;
    for (int a = 0; a < 17; a++)
      i_pfccfg_host.write(a[7:0], 8'hA5);
    chk({6'h00, hlt}, 16'h01A5);
    chk({6'h00, llt}, 16'h01A5);
    chk({2'h0, ld1}, 16'h25A5);
    chk({2'h0, hys}, 16'h25A5);
    chk({11'h000, bst}, 16'h0005);
    chk({lt, l1}, 16'hA5A5);
    chk({2'h0, ld2}, 16'h25A5);
    chk({8'h00, l2}, 16'h00A5);
    for (int a = 0; a < 17; a++) begin
      i_pfccfg_host.read(a[7:0], v[7:0]);
      e = {8'h00, msk[a] & 8'hA5};
      chk(v, e);
    end
  endtask
  // Self-clearing faults: each acts on its own stage, then all recover.
  task automatic t_faults;
    int         idx [8] = '{0, 1, 5, 6, 8, 10, 11, 14};
    logic [4:0] mk [8] = '{5'h18, 5'h18, 5'h10, 5'h10, 5'h16, 5'h16,
      5'h16, 5'h13};
    logic [4:0] vl [8] = '{5'h00, 5'h08, 5'h00, 5'h00, 5'h12, 5'h14,
      5'h14, 5'h13};
    for (int i = 0; i < 8; i++) begin
      flt[idx[i]] = 1'b1;
      cyc(8);
      chk({11'h000, st & mk[i]}, {11'h000, vl[i]});
      flt[idx[i]] = 1'b0;
      cyc(8);
      chk({11'h000, st}, 16'h0016);
    end
  endtask
  // Timed faults stop their stage until the timer has run out.
  task automatic t_timed(input int idx, input bit hb);
    flt[idx] = 1'b1;
    cyc(8);
    chk(tv(hb), 16'h0001);
    flt[idx] = 1'b0;
    cyc(12);
    chk(tv(hb), 16'h0001);
    cyc(TCYC + 10);
    chk(tv(hb), 16'h0002);
  endtask
  // Shutdown and current-limit latches hold until the supply reset.
  task automatic t_latch;
    flt[3] = 1'b1;
    cyc(8);
    chk({14'h0000, sdl, sys}, 16'h0002);
    flt[3] = 1'b0;
    cyc(20);
    chk({14'h0000, sdl, sys}, 16'h0002);
    lmode = 1'b1;
    flt[7] = 1'b1;
    cyc(8);
    flt[7] = 1'b0;
    cyc(40);
    chk({13'h0000, pfl, pfe, sys}, 16'h0004);
    flt[2] = 1'b1;
    cyc(8);
    flt[2] = 1'b0;
    cyc(8);
    chk({13'h0000, sdl, pfe, sys}, 16'h0003);
    lmode = 1'b0;
    flt[7] = 1'b1;
    cyc(8);
    chk({14'h0000, pfl, pfe}, 16'h0000);
    flt[7] = 1'b0;
    cyc(TCYC + 30);
    chk({14'h0000, pfl, pfe}, 16'h0001);
  endtask

  // Main sequence, with a second reset in mid-run.
  initial begin
    do_reset;
    t_defaults;
    t_write;
    do_reset;
    t_defaults;
    t_faults;
    t_timed(4, 1'b0);
    t_timed(9, 1'b0);
    t_timed(12, 1'b1);
    t_timed(13, 1'b1);
    t_latch;
    summarize;
  end
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    summarize;
  end
endmodule // test_pfccfg_top
`default_nettype wire
